// ### seq_pkg.sv
// Constants for the sequencer gating and reset release timer.
// Assumes a single 100 MHz core clock and a byte-wide register port.
package seq_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] GATE_SEL_ADDR = 8'h92;
  localparam logic [7:0] DOM_END_ADDR = 8'h95;
  localparam logic [7:0] PART_ADDR = 8'h96;
  localparam logic [7:0] GATE_CTL_ADDR = 8'h97;
  localparam logic [7:0] RST_TMR_ADDR = 8'h99;
  localparam logic [7:0] STEP_A_ADDR = 8'h89;
  localparam logic [7:0] STEP_B_ADDR = 8'h8b;
  // ==========================================================
  // Field positions
  localparam int DIR_UP_BIT = 6;
  localparam int DIR_DOWN_BIT = 7;
  localparam int TIMEOUT_BIT = 5;
  localparam int MODE_BIT = 4;
  localparam int RST_SRC_LO = 6;
  // ==========================================================
  // Reset values
  localparam logic [7:0] GATE_SEL_RST = 8'h00;
  localparam logic [7:0] DOM_END_RST = 8'h00;
  localparam logic [7:0] PART_RST = 8'h00;
  localparam logic [7:0] GATE_CTL_RST = 8'h00;
  localparam logic [7:0] RST_TMR_RST = 8'h40;
  localparam logic [7:0] STEP_RST = 8'h00;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SLOT_US = 32;
  localparam int SLOT_CYCLES = SLOT_US * 1000 / CLK_PERIOD_NS;
  localparam int TICK_US = 512;
  localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMEOUT_MS = 500;
  localparam int TIMEOUT_TICKS = TIMEOUT_MS * 1000 / TICK_US;
  localparam int TMR_W = 16;
  // ==========================================================
  // Encodings
  typedef enum logic [1:0] {
    SRC_WAKE = 2'b00,
    SRC_SYS_DOMAIN_UP_EVENT = 2'b01,
    SRC_MAIN_UP = 2'b10,
    SRC_LEAVE_RST = 2'b11
  } rst_src_t;
  typedef enum logic [2:0] {
    S_OFF = 3'b000,
    S_UP = 3'b001,
    S_ON = 3'b010,
    S_DOWN = 3'b011,
    S_GATE = 3'b100
  } seq_state_t;
endpackage

// ### tmr_if.sv
// Load and expiry signals between the sequencer and a down counter.
// Assumes both ends sit on the core clock.
`timescale 1ns/1ps
`default_nettype none
interface tmr_if;
  logic load;
  logic [seq_pkg::TMR_W-1:0] value;
  logic tick;
  logic done;
  logic busy;
  modport ctrl (output load, output value, output tick,
                input done, input busy);
  modport unit (input load, input value, input tick,
                output done, output busy);
endinterface
`default_nettype wire

// ### tick_timer.sv
// Down counter in units of a tick enable, with a one-cycle done pulse.
// Assumes load and tick are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module tick_timer (
  input wire logic clk,
  input wire logic rstn,
  tmr_if.unit t
);
  logic [seq_pkg::TMR_W-1:0] cnt_r;
  logic busy_r;
  logic done_r;

  // ==========================================================
  // Counter
  // A reload while busy restarts the count; zero expires at once.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (t.load) begin
        cnt_r <= t.value;
        busy_r <= (t.value != '0);
        done_r <= (t.value == '0);
      end else if (busy_r && t.tick) begin
        cnt_r <= cnt_r - 1'b1;
        if (cnt_r == 1) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign t.done = done_r;
  assign t.busy = busy_r;
endmodule
`default_nettype wire

// ### seq_gate_ctrl.sv
// Power sequencer slot stepping with gated slot and reset release timer.
// Assumes requests come from core clock logic; pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module seq_gate_ctrl #(
  parameter int TICK_CYCLES = seq_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output var logic [7:0] reg_rdata,
  input wire logic power_up_req,
  input wire logic power_down_req,
  input wire logic partial_down_req,
  input wire logic gating_input_pin,
  input wire logic external_wake_event,
  output var logic [3:0] supply_en,
  output logic [3:0] seq_slot,
  output logic seq_gated,
  output var logic gate_timeout,
  output var logic sys_domain_up_event,
  output var logic main_domain_up_event,
  output var logic sys_reset_out_n
);
  // ==========================================================
  // Local constants
  // Counters are 16 bits wide; the package counts all fit without being cut.
  localparam logic [15:0] SLOT_LAST = 16'(seq_pkg::SLOT_CYCLES - 1);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);
  localparam logic [15:0] TIMEOUT_LOAD = 16'(seq_pkg::TIMEOUT_TICKS);

  // ==========================================================
  // Register storage
  logic [7:0] gate_sel_r;
  logic [7:0] dom_end_r;
  logic [7:0] part_r;
  logic [7:0] gate_ctl_r;
  logic [7:0] rst_tmr_r;
  logic [7:0] step_a_r;
  logic [7:0] step_b_r;
  logic [7:0] rdata_nxt;

  // ==========================================================
  // Synchronisers and dividers
  logic pin_meta_r;
  logic pin_s_r;
  logic wake_meta_r;
  logic wake_s_r;
  logic wake_prev_r;
  logic [15:0] slot_cnt_r;
  logic slot_tick_r;
  logic [15:0] tick_cnt_r;
  logic tick_r;

  // ==========================================================
  // Sequencer state
  seq_pkg::seq_state_t state_r;
  logic [3:0] slot_r;
  logic dir_down_r;
  logic partial_r;
  logic gate_done_r;
  logic timeout_r;
  logic sys_domain_up_event_r;
  logic main_up_r;
  logic [3:0] en_r;
  logic rel_n_r;
  logic leave_r;
  logic leave_done_r;

  // ==========================================================
  // Field decodes
  logic [3:0] gate_step;
  logic [3:0] main_end;
  logic [3:0] sys_end;
  logic [3:0] part_slot;
  logic dir_up_en;
  logic dir_down_en;
  logic timeout_en;
  logic timer_mode;
  logic [3:0] wait_code;
  logic [1:0] rst_src;
  logic [5:0] rst_code;
  logic [3:0] sup_slot [4];
  logic act;
  logic gate_hit;
  logic gate_release;
  logic timeout_set;
  logic down_start;
  logic rst_start;
  logic [15:0] wait_ticks;
  logic [15:0] rst_ticks;

  // ==========================================================
  // Timers
  tmr_if gate_t ();
  tmr_if rst_t ();

  tick_timer u_gate_timer (
    .clk(core_clk),
    .rstn(rstn),
    .t(gate_t)
  );

  tick_timer u_rst_timer (
    .clk(core_clk),
    .rstn(rstn),
    .t(rst_t)
  );

  // ==========================================================
  // Assertion defaults
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Field decodes
  assign gate_step = gate_sel_r[3:0];
  assign main_end = dom_end_r[7:4];
  assign sys_end = dom_end_r[3:0];
  assign part_slot = part_r[7:4];
  assign dir_up_en = gate_ctl_r[seq_pkg::DIR_UP_BIT];
  assign dir_down_en = gate_ctl_r[seq_pkg::DIR_DOWN_BIT];
  assign timeout_en = gate_ctl_r[seq_pkg::TIMEOUT_BIT];
  assign timer_mode = gate_ctl_r[seq_pkg::MODE_BIT];
  assign wait_code = gate_ctl_r[3:0];
  assign rst_src = rst_tmr_r[seq_pkg::RST_SRC_LO +: 2];
  assign rst_code = rst_tmr_r[5:0];
  assign sup_slot[0] = step_a_r[3:0];
  assign sup_slot[1] = step_a_r[7:4];
  assign sup_slot[2] = step_b_r[3:0];
  assign sup_slot[3] = step_b_r[7:4];

  // ==========================================================
  // Register writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gate_sel_r <= seq_pkg::GATE_SEL_RST;
      dom_end_r <= seq_pkg::DOM_END_RST;
      part_r <= seq_pkg::PART_RST;
      gate_ctl_r <= seq_pkg::GATE_CTL_RST;
      rst_tmr_r <= seq_pkg::RST_TMR_RST;
      step_a_r <= seq_pkg::STEP_RST;
      step_b_r <= seq_pkg::STEP_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        seq_pkg::GATE_SEL_ADDR: gate_sel_r <= reg_wdata;
        seq_pkg::DOM_END_ADDR: dom_end_r <= reg_wdata;
        seq_pkg::PART_ADDR: part_r <= reg_wdata;
        seq_pkg::GATE_CTL_ADDR: gate_ctl_r <= reg_wdata;
        seq_pkg::RST_TMR_ADDR: rst_tmr_r <= reg_wdata;
        seq_pkg::STEP_A_ADDR: step_a_r <= reg_wdata;
        seq_pkg::STEP_B_ADDR: step_b_r <= reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Register reads
  // Unmapped addresses read as zero.
  always_comb begin
    rdata_nxt = 8'h00;
    case (reg_addr)
      seq_pkg::GATE_SEL_ADDR: rdata_nxt = gate_sel_r;
      seq_pkg::DOM_END_ADDR: rdata_nxt = dom_end_r;
      seq_pkg::PART_ADDR: rdata_nxt = part_r;
      seq_pkg::GATE_CTL_ADDR: rdata_nxt = gate_ctl_r;
      seq_pkg::RST_TMR_ADDR: rdata_nxt = rst_tmr_r;
      seq_pkg::STEP_A_ADDR: rdata_nxt = step_a_r;
      seq_pkg::STEP_B_ADDR: rdata_nxt = step_b_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // ==========================================================
  // Pin synchronisers
  // The first stage is never read, to keep metastability out of logic.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_r <= 1'b0;
      pin_s_r <= 1'b0;
      wake_meta_r <= 1'b0;
      wake_s_r <= 1'b0;
      wake_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= gating_input_pin;
      pin_s_r <= pin_meta_r;
      wake_meta_r <= external_wake_event;
      wake_s_r <= wake_meta_r;
      wake_prev_r <= wake_s_r;
    end
  end

  // ==========================================================
  // Slot and tick dividers
  // Both run free, so a request waits up to one slot for its first step.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      slot_cnt_r <= 16'h0000;
      slot_tick_r <= 1'b0;
    end else begin
      slot_tick_r <= (slot_cnt_r == SLOT_LAST);
      if (slot_cnt_r == SLOT_LAST) begin
        slot_cnt_r <= 16'h0000;
      end else begin
        slot_cnt_r <= slot_cnt_r + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (tick_cnt_r == TICK_LAST);
      if (tick_cnt_r == TICK_LAST) begin
        tick_cnt_r <= 16'h0000;
      end else begin
        tick_cnt_r <= tick_cnt_r + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Gating decisions
  assign act = slot_tick_r &&
      (state_r == seq_pkg::S_UP || state_r == seq_pkg::S_DOWN);
  assign gate_hit = act && !gate_done_r && (slot_r == gate_step) &&
      ((state_r == seq_pkg::S_UP) ? dir_up_en : dir_down_en);
  assign gate_release = (state_r == seq_pkg::S_GATE) &&
      (timer_mode ? gate_t.done :
       (pin_s_r || (timeout_en && gate_t.done)));
  assign timeout_set = (state_r == seq_pkg::S_GATE) && !timer_mode &&
      timeout_en && gate_t.done && !pin_s_r;
  assign down_start = (state_r == seq_pkg::S_ON) && power_down_req;

  // Code 0 is no wait; each further code doubles the tick count.
  always_comb begin
    wait_ticks = 16'h0000;
    if (wait_code != 4'h0) begin
      wait_ticks = 16'h0001 << (wait_code - 4'h1);
    end
  end

  // Fine steps of two ticks up to code 32, coarse steps of 64 beyond.
  always_comb begin
    if (rst_code <= 6'h20) begin
      rst_ticks = {9'h000, rst_code, 1'b0};
    end else begin
      rst_ticks = ({10'h000, rst_code} - 16'h001f) << 6;
    end
  end

  // Without time-out the timer still runs but its expiry is ignored.
  assign gate_t.load = gate_hit;
  assign gate_t.value = timer_mode ? wait_ticks : TIMEOUT_LOAD;
  assign gate_t.tick = tick_r;

  // ==========================================================
  // Sequencer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= seq_pkg::S_OFF;
      slot_r <= 4'h0;
      dir_down_r <= 1'b0;
      partial_r <= 1'b0;
      gate_done_r <= 1'b0;
    end else begin
      unique case (state_r)
        seq_pkg::S_OFF: begin
          if (power_up_req) begin
            state_r <= seq_pkg::S_UP;
            slot_r <= 4'h0;
            dir_down_r <= 1'b0;
            gate_done_r <= 1'b0;
          end
        end
        seq_pkg::S_UP: begin
          if (gate_hit) begin
            state_r <= seq_pkg::S_GATE;
          end else if (act) begin
            gate_done_r <= 1'b0;
            if (slot_r == main_end) begin
              state_r <= seq_pkg::S_ON;
            end else begin
              slot_r <= slot_r + 4'h1;
            end
          end
        end
        seq_pkg::S_ON: begin
          if (power_down_req || partial_down_req) begin
            state_r <= seq_pkg::S_DOWN;
            dir_down_r <= 1'b1;
            partial_r <= partial_down_req && !power_down_req;
            gate_done_r <= 1'b0;
          end else if (power_up_req && slot_r != main_end) begin
            state_r <= seq_pkg::S_UP;
            dir_down_r <= 1'b0;
          end
        end
        seq_pkg::S_DOWN: begin
          if (gate_hit) begin
            state_r <= seq_pkg::S_GATE;
          end else if (act) begin
            gate_done_r <= 1'b0;
            if (partial_r && slot_r <= part_slot) begin
              state_r <= seq_pkg::S_ON;
            end else if (slot_r == 4'h0) begin
              state_r <= seq_pkg::S_OFF;
            end else begin
              slot_r <= slot_r - 4'h1;
            end
          end
        end
        seq_pkg::S_GATE: begin
          if (gate_release) begin
            state_r <= dir_down_r ? seq_pkg::S_DOWN : seq_pkg::S_UP;
            gate_done_r <= 1'b1;
          end
        end
        default: begin
          state_r <= seq_pkg::S_OFF;
        end
      endcase
    end
  end

  // ==========================================================
  // Supply enables
  // A partial stop leaves the stop slot itself powered.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_r <= 4'h0;
    end else if (act && !gate_hit) begin
      for (int i = 0; i < 4; i++) begin
        if (sup_slot[i] == slot_r) begin
          if (state_r == seq_pkg::S_UP) begin
            en_r[i] <= 1'b1;
          end else if (!(partial_r && slot_r <= part_slot)) begin
            en_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  // ==========================================================
  // Domain events
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sys_domain_up_event_r <= 1'b0;
      main_up_r <= 1'b0;
    end else begin
      sys_domain_up_event_r <= (state_r == seq_pkg::S_UP) && act && !gate_hit &&
          (slot_r == sys_end);
      main_up_r <= (state_r == seq_pkg::S_UP) && act && !gate_hit &&
          (slot_r == main_end);
    end
  end

  // ==========================================================
  // Time-out flag
  // Set wins over the clear taken with a new power-up request.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      timeout_r <= 1'b0;
    end else if (timeout_set) begin
      timeout_r <= 1'b1;
    end else if (state_r == seq_pkg::S_OFF && power_up_req) begin
      timeout_r <= 1'b0;
    end
  end

  // ==========================================================
  // Reset release timer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      leave_r <= 1'b0;
      leave_done_r <= 1'b0;
    end else begin
      leave_r <= !leave_done_r;
      leave_done_r <= 1'b1;
    end
  end

  always_comb begin
    rst_start = 1'b0;
    unique case (seq_pkg::rst_src_t'(rst_src))
      seq_pkg::SRC_WAKE: rst_start = wake_s_r && !wake_prev_r;
      seq_pkg::SRC_SYS_DOMAIN_UP_EVENT: rst_start = sys_domain_up_event_r;
      seq_pkg::SRC_MAIN_UP: rst_start = main_up_r;
      seq_pkg::SRC_LEAVE_RST: rst_start = leave_r;
    endcase
  end

  assign rst_t.load = rst_start;
  assign rst_t.value = rst_ticks;
  assign rst_t.tick = tick_r;

  // A new start event restarts the period even if it was running.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rel_n_r <= 1'b0;
    end else if (rst_start || down_start) begin
      rel_n_r <= 1'b0;
    end else if (rst_t.done) begin
      rel_n_r <= 1'b1;
    end
  end

  // ==========================================================
  // Outputs
  assign supply_en = en_r;
  assign seq_slot = slot_r;
  assign seq_gated = (state_r == seq_pkg::S_GATE);
  assign gate_timeout = timeout_r;
  assign sys_domain_up_event = sys_domain_up_event_r;
  assign main_domain_up_event = main_up_r;
  assign sys_reset_out_n = rel_n_r;

  // ==========================================================
  // Assertions
  sequence s_up_gate_hit;
    state_r == seq_pkg::S_UP && gate_hit;
  endsequence

  sequence s_partial_stop;
    state_r == seq_pkg::S_DOWN && act && !gate_hit && partial_r &&
        slot_r <= part_slot;
  endsequence

  AST_GATE_AT_STEP: assert property (
    seq_gated |-> slot_r == gate_step)
    else $error("hold at a slot other than the step field");

  AST_GATE_DIR: assert property (
    state_r == seq_pkg::S_GATE |-> (dir_down_r ? dir_down_en : dir_up_en))
    else $error("hold in a direction that is not enabled");

  AST_GATE_ENTRY: assert property (
    s_up_gate_hit |=> state_r == seq_pkg::S_GATE)
    else $error("gated slot passed without holding");

  AST_NO_LIMIT_HOLD: assert property (
    state_r == seq_pkg::S_GATE && !timeout_en && !timer_mode && !pin_s_r
        |=> state_r == seq_pkg::S_GATE)
    else $error("hold left without pin or time-out");

  AST_TIMER_RELEASE: assert property (
    state_r == seq_pkg::S_GATE && timer_mode && gate_t.done
        |=> state_r != seq_pkg::S_GATE)
    else $error("timer expiry did not release the hold");

  AST_SLOT_STEP: assert property (
    state_r == seq_pkg::S_UP && act && !gate_hit && slot_r != main_end
        |=> slot_r == $past(slot_r) + 4'h1)
    else $error("slot did not advance by one");

  AST_RESET_HELD: assert property (
    rst_t.busy |-> !sys_reset_out_n)
    else $error("reset released while its timer runs");

  AST_PARTIAL_STOP: assert property (
    s_partial_stop |=> state_r == seq_pkg::S_ON)
    else $error("partial power-down did not stop at its slot");
endmodule
`default_nettype wire

// ### gate_host.sv
// Far side model: host raising the gating pin once the sequencer holds.
// Assumes seq_gated is a level that stays high while the slot is held.
`timescale 1ns/1ps
`default_nettype none
module gate_host (
  input wire logic core_clk,
  input wire logic seq_gated,
  output var logic gating_input_pin = 1'b0
);
  int n = 0;
  // Slow answer on purpose, so the hold is seen for some cycles
  always @(posedge core_clk) begin
    n <= seq_gated ? n + 1 : 0;
    gating_input_pin <= (n > 20);
  end
endmodule
`default_nettype wire

// ### tb.sv
// Bench for the gating and reset timer registers and a gated power-up.
// Assumes writes land on an edge with reg_wr high; reads settle in 2 edges.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 0, rstn = 0, reg_wr = 0, up = 0, dn = 0, pin, gated, rel;
  logic [3:0] sen;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
  int bad_count = 0, samples_checked = 0;
  logic [31:0] lf = 32'hfb9bbc6a;
  initial forever #5 core_clk = ~core_clk;
  seq_gate_ctrl #(.TICK_CYCLES(4)) u_seq_gate_ctrl (.core_clk, .rstn,
    .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .power_up_req(up),
    .power_down_req(dn), .partial_down_req(1'b0),
    .gating_input_pin(pin), .external_wake_event(1'b0), .supply_en(sen),
    .seq_slot(), .seq_gated(gated), .gate_timeout(),
    .sys_domain_up_event(), .main_domain_up_event(),
    .sys_reset_out_n(rel));
  gate_host u_gate_host (.core_clk, .seq_gated(gated),
    .gating_input_pin(pin));
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk) begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
    end
    @(posedge core_clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    @(posedge core_clk) reg_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 chk(reg_rdata, exp);
  endtask
  task automatic test_done;
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    logic [7:0] d;
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    rd(seq_pkg::RST_TMR_ADDR, seq_pkg::RST_TMR_RST);
    rd(seq_pkg::GATE_CTL_ADDR, seq_pkg::GATE_CTL_RST);
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      d = lf[7:0];
      wr(seq_pkg::GATE_CTL_ADDR, d);
      rd(seq_pkg::GATE_CTL_ADDR, d);
      // Top source bit is kept clear, so only the wake and sys_domain_up_event sources are picked
      wr(seq_pkg::RST_TMR_ADDR, {1'b0, d[6:0]});
      rd(seq_pkg::RST_TMR_ADDR, {1'b0, d[6:0]});
    end
    $display("register test done");
    wr(seq_pkg::STEP_A_ADDR, 8'h10);
    wr(seq_pkg::STEP_B_ADDR, 8'h32);
    wr(seq_pkg::DOM_END_ADDR, 8'h21);
    wr(seq_pkg::RST_TMR_ADDR, 8'h42);
    wr(seq_pkg::GATE_SEL_ADDR, 8'h01);
    wr(seq_pkg::GATE_CTL_ADDR, 8'h40);
    @(posedge core_clk) up <= 1'b1;
    @(posedge core_clk) up <= 1'b0;
    for (int i = 0; i < 9000 && gated !== 1'b1; i++) @(posedge core_clk);
    chk({7'h0, gated}, 8'h01);
    chk({7'h0, rel}, 8'h00);
    repeat (40) @(posedge core_clk);
    #1 chk({7'h0, gated}, 8'h00);
    repeat (6500) @(posedge core_clk);
    #1 chk({4'h0, sen}, 8'h07);
    chk({7'h0, rel}, 8'h01);
    $display("gating test done");
    @(posedge core_clk) dn <= 1'b1;
    @(posedge core_clk) dn <= 1'b0;
    repeat (9800) @(posedge core_clk);
    #1 chk({4'h0, sen}, 8'h00);
    chk({7'h0, rel}, 8'h00);
    $display("power-down test done");
    test_done();
  end
endmodule
`default_nettype wire
